// [verilog/gsel_params.svh]
// Offsets, field positions, reset values and timing counts of the gain select block
`ifndef GSEL_PARAMS_SVH
`define GSEL_PARAMS_SVH

`define GSEL_GAIN_CTRL_ADDR   7'h00
`define GSEL_GAIN_CTRL_RESET  8'h00
`define GSEL_SCALE_SEL_BIT    7
`define GSEL_GAIN_CODE_MSB    6
`define GSEL_GAIN_CODE_LSB    3
`define GSEL_RSVD_BIT         2
`define GSEL_EXT_SEL_MSB      1
`define GSEL_EXT_SEL_LSB      0
`define GSEL_GAIN_CODE_MAX    4'hb
`define GSEL_FRAME_BITS       5'h10
`define GSEL_ADDR_BITS        5'h08
`define GSEL_OV_TIME_US       200
`define GSEL_CLK_MHZ          40
`define GSEL_OV_CYCLES        (`GSEL_OV_TIME_US * `GSEL_CLK_MHZ)
`define GSEL_MANT_UNITY       4'h8
`define GSEL_MANT_ALT         4'ha
`define GSEL_MANT_SEL         4'hb

`endif

// [verilog/gsel_pkg.sv]
// Types shared by the gain select block
`default_nettype none
package gsel_pkg;
  typedef enum logic [2:0] {
    GSEL_IDLE = 3'b001,
    GSEL_ADDR = 3'b010,
    GSEL_DATA = 3'b100
  } gsel_spi_e;

  typedef logic [14:0] gsel_gain_t;
endpackage : gsel_pkg
`default_nettype wire

// [verilog/gsel_top.sv]
// Gain and external channel select register with its serial read/write port
//
// Notes on behaviour
// - Local scale bit set gives scale 1.375, alternate bit ignored.
// - Local scale bit clear: alternate bit picks scale 1 or 1.25.
// - Gain codes 0..11 give 1/16 to 128 doubling; 12..15 are reserved.
// - Overall gain equals input gain times output scaling gain.
// - Reset clears gain code, scale select and channel select to zero.
// - Scale select bit 7, gain code 6:3, reserved bit 2, channel 1:0.
// - Channel bits drive aux pins only when enabled and pin is output.
// - Gain and channel fields change together from one serial write.
// - Overvoltage over 200 us restores gain defaults and sets reset flag.
`timescale 1ns/1ps
`default_nettype none
`include "gsel_params.svh"

module gsel_top
  import gsel_pkg::*;
#(
  parameter int unsigned OV_CYCLES = `GSEL_OV_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe,
  input  wire logic       output_scale_alt,
  input  wire logic [1:0] ext_channel_enable,
  input  wire logic [1:0] aux_dir_out,
  input  wire logic       overvoltage,
  input  wire logic       gain_reset_clear,
  output logic            gain_reset_flag,
  output logic [7:0]      gain_select_ctrl,
  output logic [3:0]      gain_code,
  output logic            output_scale_sel,
  output logic            gain_code_reserved,
  output gsel_gain_t      overall_gain,
  output logic [1:0]      aux_pin_out,
  output logic [1:0]      aux_pin_oe
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // Output scaling mantissa in eighths: 8 = 1, 10 = 1.25, 11 = 1.375
  function automatic logic [3:0] scale_mant(input logic sel, input logic alt);
    scale_mant = sel ? `GSEL_MANT_SEL : (alt ? `GSEL_MANT_ALT : `GSEL_MANT_UNITY);
  endfunction : scale_mant

  // ==========================================================================
  // Serial port
  // ==========================================================================
  // Frame: read flag (1 reads), 7-bit address, 8 data bits, all MSB first.
  // Clocks past the sixteenth start a fresh frame; hosts must raise select.
  gsel_spi_e  state;
  gsel_spi_e  next_state;
  logic       sclk_q;
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  logic [7:0]  shift_out;
  logic [7:0]  ctrl;
  logic [13:0] ov_cnt;

  wire        sclk_rise  = spi_sclk & ~sclk_q & ~spi_cs_n;
  wire        sclk_fall  = ~spi_sclk & sclk_q & ~spi_cs_n;
  wire [15:0] frame      = {shift_in[14:0], spi_sdi};
  wire        frame_done = sclk_rise && (bit_cnt == `GSEL_FRAME_BITS - 5'h01);
  wire        addr_done  = sclk_rise && (bit_cnt == `GSEL_ADDR_BITS - 5'h01);
  wire        addr_hit   = (frame[14:8] == `GSEL_GAIN_CTRL_ADDR);
  wire        rd_hit     = (frame[6:0] == `GSEL_GAIN_CTRL_ADDR) && frame[7];
  wire        wr_hit     = frame_done && !frame[15] && addr_hit;

  // Reserved bit masked on write, so reads always show zero there
  wire [7:0]  wr_value   = frame[7:0] & ~(8'h01 << `GSEL_RSVD_BIT);
  // Gated by the live level, else a run that drops on the last edge still trips.
  // Counter is 14 bits, so OV_CYCLES must not exceed 16384.
  wire        ov_at_limit = (ov_cnt == OV_CYCLES[13:0] - 14'h0001);
  wire        ov_expired  = overvoltage && ov_at_limit;

  always_comb begin
    next_state = state;
    case (state)
      GSEL_IDLE: begin
        if (!spi_cs_n) begin
          next_state = GSEL_ADDR;
        end
      end
      GSEL_ADDR: begin
        if (spi_cs_n) begin
          next_state = GSEL_IDLE;
        end else if (addr_done) begin
          next_state = GSEL_DATA;
        end
      end
      GSEL_DATA: begin
        // Select raised early aborts the frame with nothing stored
        if (spi_cs_n || frame_done) begin
          next_state = GSEL_IDLE;
        end
      end
      default: next_state = GSEL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= GSEL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q   <= 1'b0;
      bit_cnt  <= 5'h00;
      shift_in <= 16'h0000;
    end else begin
      sclk_q <= spi_sclk;
      if (spi_cs_n || state == GSEL_IDLE) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        bit_cnt  <= bit_cnt + 5'h01;
        shift_in <= frame;
      end
    end
  end

  // Read data is loaded after the address byte and shifted on falling edges
  // Unmapped addresses shift out zeros; writes to them are dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_out  <= 8'h00;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo_oe <= (state == GSEL_DATA) && !spi_cs_n;
      if (addr_done) begin
        shift_out <= rd_hit ? ctrl : 8'h00;
      end else if (sclk_fall && state == GSEL_DATA) begin
        spi_sdo   <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // Overvoltage watchdog
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ov_cnt <= 14'h0000;
    end else if (!overvoltage || ov_expired) begin
      ov_cnt <= 14'h0000;
    end else begin
      ov_cnt <= ov_cnt + 14'h0001;
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================
  // Overvoltage restore beats a write in the same cycle: protection first.
  // The channel field is kept, since only gain fields are restored.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `GSEL_GAIN_CTRL_RESET;
    end else if (ov_expired) begin
      // Alternate scale bit lives outside this block and is left alone
      ctrl[`GSEL_SCALE_SEL_BIT] <= 1'b0;
      ctrl[`GSEL_GAIN_CODE_MSB:`GSEL_GAIN_CODE_LSB] <= 4'h0;
    end else if (wr_hit) begin
      ctrl <= wr_value;
    end
  end

  // Set wins over a clear arriving in the same cycle
  // Clearing the flag never brings the old gain back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_reset_flag <= 1'b0;
    end else if (ov_expired) begin
      gain_reset_flag <= 1'b1;
    end else if (gain_reset_clear) begin
      gain_reset_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Gain decode and pins
  // ==========================================================================
  wire [3:0]  code_w = ctrl[`GSEL_GAIN_CODE_MSB:`GSEL_GAIN_CODE_LSB];
  wire        rsvd_w = code_w > `GSEL_GAIN_CODE_MAX;
  wire [3:0]  mant_w = scale_mant(ctrl[`GSEL_SCALE_SEL_BIT], output_scale_alt);
  // Units of 1/128: mantissa (eighths) times 2^code (sixteenths)
  // Reserved codes report zero so they cannot pass for a real gain
  wire [14:0] prod_w = rsvd_w ? 15'h0000 : 15'({11'h000, mant_w} << code_w);
  // Pins not set up as outputs stay low with their enable off
  wire [1:0]  pin_en = ext_channel_enable & aux_dir_out;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_select_ctrl   <= `GSEL_GAIN_CTRL_RESET;
      gain_code          <= 4'h0;
      output_scale_sel   <= 1'b0;
      gain_code_reserved <= 1'b0;
      overall_gain       <= 15'h0000;
      aux_pin_out        <= 2'h0;
      aux_pin_oe         <= 2'h0;
    end else begin
      gain_select_ctrl   <= ctrl;
      gain_code          <= code_w;
      output_scale_sel   <= ctrl[`GSEL_SCALE_SEL_BIT];
      gain_code_reserved <= rsvd_w;
      overall_gain       <= prod_w;
      aux_pin_out        <= ctrl[`GSEL_EXT_SEL_MSB:`GSEL_EXT_SEL_LSB] & pin_en;
      aux_pin_oe         <= pin_en;
    end
  end

endmodule : gsel_top
`default_nettype wire

// [verification/gsel_properties.sv]
// Assertion checker for the gain select block
`timescale 1ns/1ps
`default_nettype none
module gsel_properties
  import gsel_pkg::*;
#(
  parameter int unsigned OV_CYCLES = 16
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       spi_cs_n,
  input wire logic       spi_sdo_oe,
  input wire logic       output_scale_alt,
  input wire logic [1:0] ext_channel_enable,
  input wire logic [1:0] aux_dir_out,
  input wire logic       overvoltage,
  input wire logic       gain_reset_flag,
  input wire logic [7:0] gain_select_ctrl,
  input wire logic [3:0] gain_code,
  input wire logic       output_scale_sel,
  input wire logic       gain_code_reserved,
  input wire gsel_gain_t overall_gain,
  input wire logic [1:0] aux_pin_out,
  input wire logic [1:0] aux_pin_oe
);
  // ========================================
  // Consecutive overvoltage edges, restarting at each hit
  int unsigned ov_cnt;
  wire         ov_hit = overvoltage && (ov_cnt == OV_CYCLES - 1);
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) ov_cnt <= 0;
    else ov_cnt <= (!overvoltage || ov_hit) ? 0 : ov_cnt + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Flag lands first, register output one edge later
  sequence restore_s;
    gain_reset_flag ##1 (gain_select_ctrl[7:3] == 5'h00);
  endsequence
  chk_rsvd_code: assert property (gain_code_reserved == (gain_code > 4'hb))
    else $error("reserved code flag wrong");
  chk_scale_local: assert property (output_scale_sel && !gain_code_reserved
    |-> overall_gain == (15'h000b << gain_code)) else $error("local scale gain wrong");
  chk_scale_alt: assert property ($past(nrst) && $stable(output_scale_alt)
    && !output_scale_sel && !gain_code_reserved
    |-> overall_gain == ((output_scale_alt ? 15'h000a : 15'h0008) << gain_code))
    else $error("alternate scale gain wrong");
  chk_field_map: assert property (gain_select_ctrl[7:2] == {output_scale_sel, gain_code, 1'b0})
    else $error("field mapping wrong");
  chk_aux_enable: assert property ($past(nrst)
    |-> aux_pin_oe == ($past(ext_channel_enable) & $past(aux_dir_out)))
    else $error("aux enable wrong");
  chk_aux_drive: assert property (aux_pin_out == (gain_select_ctrl[1:0] & aux_pin_oe))
    else $error("aux drive wrong");
  chk_reset_vals: assert property ($rose(nrst) |-> gain_select_ctrl == 8'h00 && !gain_reset_flag)
    else $error("reset values wrong");
  chk_ov_restore: assert property (ov_hit |=> restore_s)
    else $error("overvoltage restore missing");
  chk_ov_keep_chan: assert property (ov_hit |=> ##1
    (gain_select_ctrl[1:0] == $past(gain_select_ctrl[1:0])))
    else $error("channel field changed by restore");
  chk_sdo_idle: assert property ($past(spi_cs_n) |-> !spi_sdo_oe)
    else $error("read driver on while deselected");
endmodule : gsel_properties
bind gsel_top gsel_properties #(.OV_CYCLES(OV_CYCLES)) u_props (.clk(clk), .nrst(nrst),
  .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .output_scale_alt(output_scale_alt), .ext_channel_enable(ext_channel_enable),
  .aux_dir_out(aux_dir_out), .overvoltage(overvoltage), .gain_reset_flag(gain_reset_flag),
  .gain_select_ctrl(gain_select_ctrl), .gain_code(gain_code),
  .output_scale_sel(output_scale_sel), .gain_code_reserved(gain_code_reserved),
  .overall_gain(overall_gain), .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe));
`default_nettype wire

// [verification/gsel_spi_host.sv]
// Serial host model that sends register frames
`timescale 1ns/1ps
`default_nettype none
module gsel_spi_host (
  input  wire logic clk,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  input  wire logic spi_sdo,
  output logic      spi_sdi
);
  // ========================================
  // Frame engine; half sets serial half period in clk cycles
  int half = 3;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi  = 1'b0;
  end
  // One frame carries gain and channel; wider channel counts need more frames
  task automatic frame(input logic [15:0] w, input int n, output logic [7:0] q);
    q = 8'h00;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_sdi  <= w[15-i];
      spi_sclk <= 1'b0;
      repeat (half) @(posedge clk);
      spi_sclk <= 1'b1;
      if (i > 7) q = {q[6:0], spi_sdo};
      repeat (half) @(posedge clk);
    end
    // Released data line shows no stale bit
    spi_sdi  <= ~spi_sdi;
    spi_sclk <= 1'b0;
    spi_cs_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : frame
endmodule : gsel_spi_host
`default_nettype wire

// [verification/gsel_top_tb.sv]
// Self-checking bench for the gain select block
`timescale 1ns/1ps
`default_nettype none
module gsel_top_tb;
  import gsel_pkg::*;
  // ========================================
  // Stimulus, instances and checks
  logic       clk = 1'b0, nrst = 1'b0, alt = 1'b0, ov = 1'b0, clr = 1'b0;
  logic       cs_n, sclk, sdi, sdo, oe, flag, sel, rsvd, oe_seen = 1'b0;
  logic [1:0] en = 2'h0, dir = 2'h0, aout, aoe;
  logic [3:0] code;
  logic [7:0] ctrl, q;
  gsel_gain_t gain;
  int         fails = 0, n_checks = 0, cyc = 0;
  gsel_top #(.OV_CYCLES(16)) dut (.clk(clk), .nrst(nrst), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .output_scale_alt(alt),
    .ext_channel_enable(en), .aux_dir_out(dir), .overvoltage(ov), .gain_reset_clear(clr),
    .gain_reset_flag(flag), .gain_select_ctrl(ctrl), .gain_code(code), .output_scale_sel(sel),
    .gain_code_reserved(rsvd), .overall_gain(gain), .aux_pin_out(aout), .aux_pin_oe(aoe));
  gsel_spi_host host (.clk(clk), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdo(sdo), .spi_sdi(sdi));
  always #12.5 clk = ~clk;
  always @(posedge clk) if (oe) oe_seen <= 1'b1;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] eg(input logic s, input logic a, input logic [3:0] c);
    return (c > 4'hb) ? 16'h0000 : (s ? 16'h000b : a ? 16'h000a : 16'h0008) << c;
  endfunction : eg
  task automatic rd;
    host.frame(16'h8000, 16, q);
  endtask : rd
  task automatic t_gains;
    for (int i = 0; i < 64; i++) begin
      alt <= i[5];
      host.half = i[0] ? 3 : 6;
      host.frame({8'h00, i[4], i[3:0], 1'b1, i[1:0]}, 16, q);
      rd();
      chk(16'(q), 16'({i[4], i[3:0], 1'b0, i[1:0]}));
      chk(16'(gain), eg(i[4], i[5], i[3:0]));
      chk(16'(rsvd), 16'(i[3:0] > 4'hb));
    end
    chk(16'(oe_seen), 16'h0001);
  endtask : t_gains
  task automatic t_aux;
    host.frame(16'h001a, 16, q);
    for (int j = 0; j < 16; j++) begin
      en  <= j[1:0];
      dir <= j[3:2];
      repeat (3) @(posedge clk);
      chk(16'(aoe), 16'(j[1:0] & j[3:2]));
      chk(16'(aout), 16'(2'h2 & j[1:0] & j[3:2]));
    end
  endtask : t_aux
  task automatic t_refuse;
    host.frame(16'h05ff, 16, q);
    host.frame(16'h8500, 16, q);
    chk(16'(q), 16'h0000);
    host.frame(16'h00ff, 12, q);
    chk(16'(ctrl), 16'h001a);
  endtask : t_refuse
  task automatic t_ov;
    host.frame(16'h00fb, 16, q);
    chk(16'(ctrl), 16'h00fb);
    // Clear held across the expiry edge: the set must win
    ov  <= 1'b1;
    clr <= 1'b1;
    repeat (16) @(posedge clk);
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    ov <= 1'b0;
    chk(16'(flag), 16'h0001);
    chk(16'(ctrl), 16'h0003);
    chk(16'(gain), eg(1'b0, alt, 4'h0));
    clr <= 1'b1;
    repeat (2) @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    chk(16'(flag), 16'h0000);
  endtask : t_ov
  task automatic t_reset;
    host.frame(16'h00fb, 16, q);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(16'(ctrl), 16'h0000);
    chk(16'({sel, code}), 16'h0000);
    nrst <= 1'b1;
    host.frame(16'h0048, 16, q);
    chk(16'(ctrl), 16'h0048);
    chk(16'(gain), eg(1'b0, alt, 4'h9));
  endtask : t_reset
  task automatic finish_test;
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(16'(ctrl), 16'h0000);
    chk(16'(gain), 16'h0008);
    t_gains();
    t_aux();
    t_refuse();
    t_ov();
    t_reset();
    finish_test();
  end
endmodule : gsel_top_tb
`default_nettype wire
